//--- ctam_chain_model.sv
`timescale 1ns/1ps
// daisy chain stand-in: answers each poll after 20 clocks, or never
module ctam_chain_model (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        poll_i,
   input  wire logic        answer_i,
   input  wire logic [15:0] status_i,
   output logic             start_o = 1'b0,
   output logic             done_o = 1'b0,
   output logic             valid_o = 1'b0,
   output logic [15:0]      status_o = 16'h0000
);
   int cnt_q = 0;
   always @(posedge clk_i) begin
      start_o <= 1'b0;
      done_o <= 1'b0;
      valid_o <= 1'b0;
      // idle word toggles so a stale value never passes for a fresh one
      status_o <= ~status_o;
      if (srst_i) begin
         cnt_q <= 0;
      end else if (poll_i) begin
         start_o <= 1'b1;
         cnt_q <= 20;
      end else if (cnt_q > 1) begin
         cnt_q <= cnt_q - 1;
      end else if (cnt_q == 1) begin
         cnt_q <= 0;
         done_o <= answer_i;
         valid_o <= answer_i;
         status_o <= status_i;
      end
   end
endmodule // ctam_chain_model

//--- ctam_pkg.sv
package ctam_pkg;
   // register word addresses on the plain port (printed write offsets)
   localparam logic [7:0] ADDR_COMM_CFG      = 8'h76;
   localparam logic [7:0] ADDR_POLL_CFG      = 8'h74;
   localparam logic [7:0] ADDR_FILT_MASK_LO  = 8'h78;
   localparam logic [7:0] ADDR_FILT_MASK_HI  = 8'h7a;
   localparam logic [7:0] ADDR_RAW_MASK_LO   = 8'h7c;
   localparam logic [7:0] ADDR_RAW_MASK_HI   = 8'h7e;
   localparam logic [7:0] ADDR_BAUD_DIV      = 8'h90;
   localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h92;
   localparam logic [7:0] ADDR_IRQ_CLEAR     = 8'h94;
   localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h96;
   localparam logic [7:0] ADDR_MODE          = 8'h98;
   localparam logic [7:0] ADDR_LINK_STATE    = 8'h9a;

   // reset values
   localparam logic [7:0] RST_FILT_MASK_LO   = 8'h20;
   localparam logic [7:0] RST_FILT_MASK_HI   = 8'h40;
   localparam logic [7:0] RST_RAW_MASK_LO    = 8'h20;
   localparam logic [7:0] RST_RAW_MASK_HI    = 8'h40;
   localparam logic [2:0] RST_TIMEOUT_SEL    = 3'h1;
   localparam logic [1:0] RST_POLL_SEL       = 2'h0;
   localparam logic [7:0] RST_BAUD_DIV       = 8'h0a;

   // field positions
   localparam int TOSEL_LSB    = 0;
   localparam int TOSEL_DIS    = 2;
   localparam int POLLSEL_LSB  = 4;
   localparam int IRQ_LINK_TO  = 0;
   localparam int IRQ_POLL_TO  = 1;
   localparam int IRQ_PKT_ERR  = 2;

   // timeout lengths in bit times
   localparam logic [10:0] TO_BITS_0 = 11'd276;
   localparam logic [10:0] TO_BITS_1 = 11'd516;
   localparam logic [10:0] TO_BITS_2 = 11'd996;
   localparam logic [10:0] TO_BITS_3 = 11'd1956;

   // poll interval in milliseconds and cycles at 20 MHz
   localparam int CLK_HZ       = 20_000_000;
   localparam int POLL_MS_0    = 500;
   localparam int POLL_MS_1    = 1000;
   localparam int POLL_MS_2    = 1500;
   localparam int POLL_CYC_0   = POLL_MS_0 * (CLK_HZ / 1000);
   localparam int POLL_CYC_1   = POLL_MS_1 * (CLK_HZ / 1000);
   localparam int POLL_CYC_2   = POLL_MS_2 * (CLK_HZ / 1000);

   typedef enum logic [1:0] {
      CTAM_MODE_NORMAL,
      CTAM_MODE_SLEEP,
      CTAM_MODE_SAFETY_MONITOR
   } ctam_mode_t;
endpackage

//--- ctam_poll_timer.sv
`timescale 1ns/1ps
module ctam_poll_timer #(
   parameter int POLL_CYC_0 = ctam_pkg::POLL_CYC_0,
   parameter int POLL_CYC_1 = ctam_pkg::POLL_CYC_1,
   parameter int POLL_CYC_2 = ctam_pkg::POLL_CYC_2
) (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic        run_i,
   input  wire logic [1:0]  sel_i,
   output logic             fire_o
);
   logic [31:0] cnt_q;
   logic [31:0] period;

   // code 3 is reserved; treated like the slowest interval
   always_comb begin
      case (sel_i)
         2'd0:    period = 32'(POLL_CYC_0);
         2'd1:    period = 32'(POLL_CYC_1);
         default: period = 32'(POLL_CYC_2);
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i || !run_i) begin
         cnt_q  <= 32'h0000_0000;
         fire_o <= 1'b0;
      end else if (cnt_q + 32'h0000_0001 >= period) begin
         cnt_q  <= 32'h0000_0000;
         fire_o <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h0000_0001;
         fire_o <= 1'b0;
      end
   end
endmodule // ctam_poll_timer

//--- ctam_timeout_timer.sv
`timescale 1ns/1ps
module ctam_timeout_timer (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic        start_i,
   input  wire logic        done_i,
   input  wire logic [2:0]  sel_i,
   input  wire logic [7:0]  baud_div_i,
   output logic             busy_o,
   output logic             expire_o
);
   logic [7:0]  div_q;
   logic [10:0] bits_q;
   logic [10:0] limit;
   logic        tick;

   function automatic logic [10:0] bits_of(input logic [1:0] code);
      case (code)
         2'd0:    bits_of = ctam_pkg::TO_BITS_0;
         2'd1:    bits_of = ctam_pkg::TO_BITS_1;
         2'd2:    bits_of = ctam_pkg::TO_BITS_2;
         default: bits_of = ctam_pkg::TO_BITS_3;
      endcase
   endfunction

   assign limit = bits_of(sel_i[1:0]);
   // one bit time is baud_div_i+1 clocks, so timeout tracks the baud rate
   assign tick  = busy_o && (div_q == baud_div_i);

   always_ff @(posedge core_clk_i) begin
      if (srst_i || start_i || !busy_o || tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         busy_o <= 1'b0;
         bits_q <= 11'd0;
      end else if (start_i) begin
         busy_o <= !sel_i[ctam_pkg::TOSEL_DIS];
         bits_q <= 11'd0;
      end else if (done_i) begin
         busy_o <= 1'b0;
         bits_q <= 11'd0;
      end else if (tick) begin
         bits_q <= bits_q + 11'd1;
         if (bits_q + 11'd1 >= limit) begin
            busy_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         expire_o <= 1'b0;
      end else begin
         expire_o <= busy_o && tick && !start_i && !done_i && (bits_q + 11'd1 >= limit);
      end
   end
endmodule // ctam_timeout_timer

//--- ctam_top.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module ctam_top #(
   parameter int POLL_CYC_0 = ctam_pkg::POLL_CYC_0,
   parameter int POLL_CYC_1 = ctam_pkg::POLL_CYC_1,
   parameter int POLL_CYC_2 = ctam_pkg::POLL_CYC_2
) (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [7:0]       reg_rdata_o,
   input  wire logic        txn_start_i,
   input  wire logic        txn_done_i,
   input  wire logic [15:0] pkt_status_i,
   input  wire logic        pkt_status_valid_i,
   output logic             alert_poll_command_o,
   output logic             link_timeout_flag_o,
   output logic             poll_timeout_flag_o,
   output logic             safe_monitor_alarm_o,
   output logic             sleep_alarm_o,
   output logic             alert_packet_fault_flag_o,
   output logic             irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   logic [2:0]  timeout_sel_q;
   logic [1:0]  poll_sel_q;
   logic [7:0]  baud_div_q;
   logic [15:0] filt_mask_q;
   logic [15:0] raw_mask_q;
   logic [1:0]  mode_q;
   logic [2:0]  irq_stat_q;
   logic [2:0]  irq_en_q;
   logic [15:0] pkt_q;
   logic        timer_busy;
   logic        timer_expire;
   logic        poll_fire;
   logic        low_power;
   logic        wr_clear;
   logic [2:0]  events;

   function automatic logic wr_at(input logic [7:0] a);
      wr_at = reg_wr_i && (reg_addr_i == a);
   endfunction

   assign low_power = (mode_q == 2'(ctam_pkg::CTAM_MODE_SLEEP)) ||
                      (mode_q == 2'(ctam_pkg::CTAM_MODE_SAFETY_MONITOR));
   assign wr_clear  = wr_at(ctam_pkg::ADDR_IRQ_CLEAR);

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         timeout_sel_q <= ctam_pkg::RST_TIMEOUT_SEL;
         poll_sel_q    <= ctam_pkg::RST_POLL_SEL;
         baud_div_q    <= ctam_pkg::RST_BAUD_DIV;
         mode_q        <= 2'(ctam_pkg::CTAM_MODE_NORMAL);
         irq_en_q      <= 3'h0;
      end else begin
         if (wr_at(ctam_pkg::ADDR_COMM_CFG)) begin
            timeout_sel_q <= reg_wdata_i[ctam_pkg::TOSEL_LSB +: 3];
         end
         if (wr_at(ctam_pkg::ADDR_POLL_CFG)) begin
            poll_sel_q <= reg_wdata_i[ctam_pkg::POLLSEL_LSB +: 2];
         end
         if (wr_at(ctam_pkg::ADDR_BAUD_DIV)) begin
            baud_div_q <= reg_wdata_i;
         end
         if (wr_at(ctam_pkg::ADDR_MODE)) begin
            // code 3 is unused; kept out so the mode stays decodable
            mode_q <= (reg_wdata_i[1:0] == 2'h3) ? mode_q : reg_wdata_i[1:0];
         end
         if (wr_at(ctam_pkg::ADDR_IRQ_ENABLE)) begin
            irq_en_q <= reg_wdata_i[2:0];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         filt_mask_q <= {ctam_pkg::RST_FILT_MASK_HI, ctam_pkg::RST_FILT_MASK_LO};
         raw_mask_q  <= {ctam_pkg::RST_RAW_MASK_HI, ctam_pkg::RST_RAW_MASK_LO};
      end else begin
         if (wr_at(ctam_pkg::ADDR_FILT_MASK_LO)) begin
            filt_mask_q[7:0] <= reg_wdata_i;
         end
         if (wr_at(ctam_pkg::ADDR_FILT_MASK_HI)) begin
            filt_mask_q[15:8] <= reg_wdata_i;
         end
         if (wr_at(ctam_pkg::ADDR_RAW_MASK_LO)) begin
            raw_mask_q[7:0] <= reg_wdata_i;
         end
         if (wr_at(ctam_pkg::ADDR_RAW_MASK_HI)) begin
            raw_mask_q[15:8] <= reg_wdata_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timeout supervision runs regardless of mode; the poll timer runs only in sleep and safety monitor
   ctam_timeout_timer u_timer (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .start_i    (txn_start_i),
      .done_i     (txn_done_i),
      .sel_i      (timeout_sel_q),
      .baud_div_i (baud_div_q),
      .busy_o     (timer_busy),
      .expire_o   (timer_expire)
   );

   ctam_poll_timer #(
      .POLL_CYC_0 (POLL_CYC_0),
      .POLL_CYC_1 (POLL_CYC_1),
      .POLL_CYC_2 (POLL_CYC_2)
   ) u_poll (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .run_i      (low_power),
      .sel_i      (poll_sel_q),
      .fire_o     (poll_fire)
   );

   assign alert_poll_command_o = poll_fire;

   ////////////////////////////////////////////////////////////////////////////
   // alarm masking
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pkt_q <= 16'h0000;
      end else if (pkt_status_valid_i) begin
         pkt_q <= pkt_status_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         safe_monitor_alarm_o <= 1'b0;
         sleep_alarm_o        <= 1'b0;
      end else begin
         safe_monitor_alarm_o <= (mode_q == 2'(ctam_pkg::CTAM_MODE_SAFETY_MONITOR)) && |(pkt_q & ~filt_mask_q);
         sleep_alarm_o        <= (mode_q == 2'(ctam_pkg::CTAM_MODE_SLEEP)) && |(pkt_q & ~filt_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky flags; a set in the clear cycle wins
   assign events[ctam_pkg::IRQ_LINK_TO] = timer_expire;
   assign events[ctam_pkg::IRQ_POLL_TO] = timer_expire && low_power;
   assign events[ctam_pkg::IRQ_PKT_ERR] = pkt_status_valid_i && |(pkt_status_i & ~raw_mask_q);

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         irq_stat_q <= 3'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~(wr_clear ? reg_wdata_i[2:0] : 3'h0)) | events;
      end
   end

   assign link_timeout_flag_o       = irq_stat_q[ctam_pkg::IRQ_LINK_TO];
   assign poll_timeout_flag_o       = irq_stat_q[ctam_pkg::IRQ_POLL_TO];
   assign alert_packet_fault_flag_o = irq_stat_q[ctam_pkg::IRQ_PKT_ERR];
   assign irq_o                     = |(irq_stat_q & irq_en_q);

   ////////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after strobe, unmapped reads zero
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            ctam_pkg::ADDR_COMM_CFG:     reg_rdata_o <= {5'h00, timeout_sel_q};
            ctam_pkg::ADDR_POLL_CFG:     reg_rdata_o <= {2'h0, poll_sel_q, 4'h0};
            ctam_pkg::ADDR_FILT_MASK_LO: reg_rdata_o <= filt_mask_q[7:0];
            ctam_pkg::ADDR_FILT_MASK_HI: reg_rdata_o <= filt_mask_q[15:8];
            ctam_pkg::ADDR_RAW_MASK_LO:  reg_rdata_o <= raw_mask_q[7:0];
            ctam_pkg::ADDR_RAW_MASK_HI:  reg_rdata_o <= raw_mask_q[15:8];
            ctam_pkg::ADDR_BAUD_DIV:     reg_rdata_o <= baud_div_q;
            ctam_pkg::ADDR_IRQ_STATUS:   reg_rdata_o <= {5'h00, irq_stat_q};
            ctam_pkg::ADDR_IRQ_ENABLE:   reg_rdata_o <= {5'h00, irq_en_q};
            ctam_pkg::ADDR_MODE:         reg_rdata_o <= {6'h00, mode_q};
            ctam_pkg::ADDR_LINK_STATE:   reg_rdata_o <= {7'h00, timer_busy};
            default:                     reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end
endmodule // ctam_top

//--- ctam_top_properties.sv
`timescale 1ns/1ps
module ctam_top_properties (
   input wire logic       core_clk_i,
   input wire logic       srst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       txn_start_i,
   input wire logic       pkt_status_valid_i,
   input wire logic       alert_poll_command_o,
   input wire logic       link_timeout_flag_o,
   input wire logic       poll_timeout_flag_o,
   input wire logic       safe_monitor_alarm_o,
   input wire logic       sleep_alarm_o,
   input wire logic       alert_packet_fault_flag_o,
   input wire logic       irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   // clear strobe for the link flag; one cycle back too, for latency slack
   logic clr_link;
   assign clr_link = reg_wr_i && reg_addr_i == ctam_pkg::ADDR_IRQ_CLEAR && reg_wdata_i[0];
   ////////////////////////////////////////////////////////////////////////
   a_link_flag_sticky: assert property (
      link_timeout_flag_o && !clr_link && !$past(clr_link) |=> link_timeout_flag_o)
      else $error("link timeout flag dropped without a clear");
   a_poll_with_link: assert property (
      $rose(poll_timeout_flag_o) |-> link_timeout_flag_o)
      else $error("poll timeout flag set without link timeout");
   a_poll_pulse_single: assert property (
      alert_poll_command_o |=> !alert_poll_command_o)
      else $error("poll command longer than one cycle");
   a_alarm_one_mode: assert property (
      !(safe_monitor_alarm_o && sleep_alarm_o))
      else $error("both mode alarms high");
   // shortest timeout is 276 clocks, so a fresh start never expires soon
   a_no_early_timeout: assert property (
      txn_start_i |-> ##3 (!$rose(link_timeout_flag_o)) [*8])
      else $error("timeout flag right after transaction start");
   a_fault_from_packet: assert property (
      $rose(alert_packet_fault_flag_o) |-> $past(pkt_status_valid_i))
      else $error("packet fault without packet status");
   a_irq_needs_flag: assert property (
      !(link_timeout_flag_o || poll_timeout_flag_o || alert_packet_fault_flag_o) |-> !irq_o)
      else $error("interrupt with no status bit set");
   a_rdata_idle_zero: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside the read slot");
   c_link_timeout: cover property ($rose(link_timeout_flag_o));
   c_poll_timeout: cover property ($rose(poll_timeout_flag_o));
   c_poll_command: cover property (alert_poll_command_o);
   c_sleep_alarm: cover property ($rose(sleep_alarm_o));
endmodule // ctam_top_properties

bind ctam_top ctam_top_properties u_props (
   .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .txn_start_i(txn_start_i),
   .pkt_status_valid_i(pkt_status_valid_i), .alert_poll_command_o(alert_poll_command_o),
   .link_timeout_flag_o(link_timeout_flag_o), .poll_timeout_flag_o(poll_timeout_flag_o),
   .safe_monitor_alarm_o(safe_monitor_alarm_o), .sleep_alarm_o(sleep_alarm_o),
   .alert_packet_fault_flag_o(alert_packet_fault_flag_o), .irq_o(irq_o));

//--- ctam_top_test.sv
`timescale 1ns/1ps
module ctam_top_test;
   logic        core_clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic        tb_start = 1'b0;
   logic        tb_done = 1'b0;
   logic        answer = 1'b0;
   logic [15:0] status_in = 16'h0000;
   logic [7:0]  rdata;
   logic [15:0] m_status;
   logic        m_start, m_done, m_valid, poll, link_to, poll_to, safe_al, sleep_al, fault, irq;
   int          failures = 0;
   int          checks = 0;
   int          n;
   // timeout table: select, divider, bit count
   logic [2:0]  sel_t [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0};
   logic [7:0]  div_t [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
   int          bits_t [5] = '{276, 516, 996, 1956, 276};
   always #25 core_clk_i = ~core_clk_i;
   ////////////////////////////////////////////////////////////////////////
   // poll period above the shortest timeout, else each poll restarts it
   ctam_top #(.POLL_CYC_0(400), .POLL_CYC_1(800), .POLL_CYC_2(1200)) dut (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(rdata), .txn_start_i(tb_start | m_start), .txn_done_i(tb_done | m_done),
      .pkt_status_i(m_status), .pkt_status_valid_i(m_valid), .alert_poll_command_o(poll),
      .link_timeout_flag_o(link_to), .poll_timeout_flag_o(poll_to), .safe_monitor_alarm_o(safe_al),
      .sleep_alarm_o(sleep_al), .alert_packet_fault_flag_o(fault), .irq_o(irq));
   ctam_chain_model u_chain (
      .clk_i(core_clk_i), .srst_i(srst_i), .poll_i(poll), .answer_i(answer), .status_i(status_in),
      .start_o(m_start), .done_o(m_done), .valid_o(m_valid), .status_o(m_status));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         failures++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task automatic final_report();
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      chk(rdata === e, "register read");
   endtask
   task automatic pulse(input bit d);
      @(posedge core_clk_i);
      if (d) tb_done <= 1'b1; else tb_start <= 1'b1;
      @(posedge core_clk_i);
      tb_done <= 1'b0;
      tb_start <= 1'b0;
   endtask
   function automatic logic pick(input int k);
      return (k == 0) ? link_to : (k == 1) ? sleep_al : safe_al;
   endfunction
   task automatic wt(input int k, output int c);
      c = 0;
      while (pick(k) !== 1'b1) begin
         @(negedge core_clk_i);
         c++;
         if (c > 3000) begin
            chk(1'b0, "wait ran out");
            final_report();
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk_i);
      srst_i <= 1'b0;
      rd(ctam_pkg::ADDR_FILT_MASK_LO, 8'h20);
      rd(ctam_pkg::ADDR_FILT_MASK_HI, 8'h40);
      rd(ctam_pkg::ADDR_RAW_MASK_LO, 8'h20);
      rd(ctam_pkg::ADDR_RAW_MASK_HI, 8'h40);
      rd(ctam_pkg::ADDR_COMM_CFG, 8'h01);
      rd(8'h50, 8'h00);
      wr(ctam_pkg::ADDR_POLL_CFG, 8'h30);
      rd(ctam_pkg::ADDR_POLL_CFG, 8'h30);
      wr(ctam_pkg::ADDR_POLL_CFG, 8'h00);
      wr(ctam_pkg::ADDR_IRQ_ENABLE, 8'h07);
      for (int i = 0; i < 5; i++) begin
         wr(ctam_pkg::ADDR_BAUD_DIV, div_t[i]);
         wr(ctam_pkg::ADDR_COMM_CFG, {5'h00, sel_t[i]});
         pulse(1'b0);
         wt(0, n);
         n = n - bits_t[i] * (int'(div_t[i]) + 1);
         chk(n >= -1 && n <= 4, "timeout length");
         chk(poll_to === 1'b0 && irq === 1'b1, "normal mode flags");
         rd(ctam_pkg::ADDR_IRQ_STATUS, 8'h01);
         wr(ctam_pkg::ADDR_IRQ_CLEAR, 8'h01);
         @(negedge core_clk_i);
         chk(link_to === 1'b0 && irq === 1'b0, "flag clear");
      end
      // select code 0 counts 276 bits at divider 1, 552 clocks, so 2100 clocks proves disable
      wr(ctam_pkg::ADDR_COMM_CFG, 8'h04);
      pulse(1'b0);
      repeat (2100) @(negedge core_clk_i);
      chk(link_to === 1'b0, "disabled timer fired");
      // one clock per bit: 276 clocks, so a lost stop fires inside the wait and sleep polls never restart it
      wr(ctam_pkg::ADDR_BAUD_DIV, 8'h00);
      wr(ctam_pkg::ADDR_COMM_CFG, 8'h00);
      pulse(1'b0);
      repeat (100) @(negedge core_clk_i);
      pulse(1'b1);
      repeat (400) @(negedge core_clk_i);
      chk(link_to === 1'b0, "completed transaction timed out");
      rd(ctam_pkg::ADDR_LINK_STATE, 8'h00);
      // sleep with a silent chain: poll, then link and poll timeouts
      wr(ctam_pkg::ADDR_MODE, 8'h01);
      wt(0, n);
      chk(n <= 690 && poll_to === 1'b1, "sleep poll timeout");
      wr(ctam_pkg::ADDR_IRQ_CLEAR, 8'h07);
      answer <= 1'b1;
      status_in <= 16'h0001;
      wt(1, n);
      chk(fault === 1'b1 && link_to === 1'b0, "sleep answer");
      wr(ctam_pkg::ADDR_FILT_MASK_LO, 8'h01);
      repeat (3) @(negedge core_clk_i);
      chk(sleep_al === 1'b0, "masked sleep alarm");
      wr(ctam_pkg::ADDR_FILT_MASK_LO, 8'h20);
      wr(ctam_pkg::ADDR_MODE, 8'h02);
      wt(2, n);
      chk(sleep_al === 1'b0, "safety monitor alarm");
      status_in <= 16'h4000;
      wr(ctam_pkg::ADDR_IRQ_CLEAR, 8'h07);
      repeat (900) @(negedge core_clk_i);
      chk(safe_al === 1'b0 && fault === 1'b0, "chain reset bit masked");
      wr(ctam_pkg::ADDR_FILT_MASK_HI, 8'h00);
      repeat (3) @(negedge core_clk_i);
      chk(safe_al === 1'b1, "chain reset bit unmasked");
      final_report();
   end
endmodule // ctam_top_test
